/* File: hw/ivca_top.sv */
// Integrating value counter with alarm limit, loop and saturate alarm modes, Wishbone slave
//
// Function
// - Integrate the area under the selected signal into the accumulated value.
// - Raise alarm when area exceeds limit and alarm enable bit 1 is set.
// - Take one sample of the selected signal every half second.
// - Integrate the scaled value of the signal, not its raw value.
// - Software reads the accumulated count; writing its register clears it.
// - Status bit 4 is set once the count has passed the alarm limit.
// - Loop mode (bit 0 = 0): enabled alarm stays active for ten seconds.
// - Saturate mode (bit 0 = 1): enabled alarm stays active until reset.
// - The integrated input is the signal named by the source select.
// - Each sample is divided by the divisor, from 1 upward, before adding.
// - Alarm limit accepts values from zero to 2147483647.
`include "ivca_map.svh"

module ivca_top
  import ivca_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = `IVCA_SAMPLE_CYCLES,
  parameter int unsigned ALARM_CYCLES  = `IVCA_ALARM_CYCLES
) (
  input  wire logic        clk_i,              // System clock, 40 MHz
  input  wire logic        rst_i,              // Synchronous reset, active high
  input  wire logic        wb_cyc_i,           // Wishbone cycle
  input  wire logic        wb_stb_i,           // Wishbone strobe
  input  wire logic        wb_we_i,            // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,           // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,           // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,           // Wishbone write data
  output logic      [31:0] wb_dat_o,           // Wishbone read data
  output logic             wb_ack_o,           // Wishbone acknowledge
  input  wire logic [31:0] signal0_i,          // Scaled monitored signal 0, signed
  input  wire logic [31:0] signal1_i,          // Scaled monitored signal 1, signed
  input  wire logic [31:0] signal2_i,          // Scaled monitored signal 2, signed
  input  wire logic [31:0] signal3_i,          // Scaled monitored signal 3, signed
  output logic             alarm_o,            // Counter alarm, active high
  output logic             limit_exceeded_o,   // Count has passed the limit
  output logic             irq_o               // Interrupt, active high level
);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Address match of a word register
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] offset);
    return adr[7:2] == offset[7:2];
  endfunction

  logic        bus_req;
  logic        bus_wr;
  logic [31:0] wr_cfg;
  logic [31:0] wr_src;
  logic [31:0] wr_lim;
  logic [31:0] wr_div;
  logic [31:0] wr_msk;

  logic [1:0]  integrator_config;
  logic [1:0]  integrator_source_select;
  logic [30:0] integrator_alarm_limit;
  logic [30:0] integrator_divisor;
  logic [31:0] integrator_accumulated_value;
  logic        exceeded;
  logic        alarm;
  logic [31:0] alarm_timer;
  logic [2:0]  int_status;
  logic [2:0]  int_mask;
  logic [2:0]  int_event;

  logic        sample_tick;
  ivca_state_t state;
  logic [31:0] sample;
  logic        div_start;
  logic        div_busy;
  logic        div_done;
  logic [31:0] quotient;
  logic [32:0] sum_wide;
  logic [31:0] next_value;
  logic        next_over;
  logic        count_reset;
  logic        loop_mode;
  logic        alarm_en;
  logic        alarm_expire;
  logic [31:0] scaled [4];
  logic [31:0] clamped [4];

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;
  assign wr_cfg  = merge_lanes({30'h0, integrator_config}, wb_dat_i, wb_sel_i);
  assign wr_src  = merge_lanes({30'h0, integrator_source_select}, wb_dat_i, wb_sel_i);
  assign wr_lim  = merge_lanes({1'b0, integrator_alarm_limit}, wb_dat_i, wb_sel_i);
  assign wr_div  = merge_lanes({1'b0, integrator_divisor}, wb_dat_i, wb_sel_i);
  assign wr_msk  = merge_lanes({29'h0, int_mask}, wb_dat_i, wb_sel_i);

  assign loop_mode = !integrator_config[`IVCA_CFG_MODE_BIT];
  assign alarm_en  = integrator_config[`IVCA_CFG_ALARM_EN_BIT];

  assign count_reset = bus_wr && hit(wb_adr_i, `IVCA_ADR_VALUE);

  // Single-cycle ack; unmapped reads return zero and unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i[7:2])
        6'(`IVCA_ADR_CONFIG >> 2):     wb_dat_o <= {30'h0, integrator_config};
        6'(`IVCA_ADR_SOURCE >> 2):     wb_dat_o <= {30'h0, integrator_source_select};
        6'(`IVCA_ADR_LIMIT >> 2):      wb_dat_o <= {1'b0, integrator_alarm_limit};
        6'(`IVCA_ADR_DIVISOR >> 2):    wb_dat_o <= {1'b0, integrator_divisor};
        6'(`IVCA_ADR_VALUE >> 2):      wb_dat_o <= integrator_accumulated_value;
        6'(`IVCA_ADR_STATUS >> 2): begin
          wb_dat_o <= 32'h00000000;
          wb_dat_o[`IVCA_STAT_ALARM_BIT]    <= alarm;
          wb_dat_o[`IVCA_STAT_BUSY_BIT]     <= div_busy || state != IVCA_IDLE;
          wb_dat_o[`IVCA_STAT_EXCEEDED_BIT] <= exceeded;
        end
        6'(`IVCA_ADR_INT_STATUS >> 2): wb_dat_o <= {29'h0, int_status};
        6'(`IVCA_ADR_INT_MASK >> 2):   wb_dat_o <= {29'h0, int_mask};
        default:                   wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      integrator_config        <= `IVCA_CONFIG_RESET;
      integrator_source_select <= `IVCA_SOURCE_RESET;
      integrator_alarm_limit   <= `IVCA_LIMIT_RESET;
      integrator_divisor       <= `IVCA_DIVISOR_RESET;
      int_mask                 <= `IVCA_MASK_RESET;
    end else if (bus_wr) begin
      if (hit(wb_adr_i, `IVCA_ADR_CONFIG)) begin
        integrator_config <= wr_cfg[1:0];
      end
      if (hit(wb_adr_i, `IVCA_ADR_SOURCE)) begin
        integrator_source_select <= wr_src[1:0];
      end
      if (hit(wb_adr_i, `IVCA_ADR_LIMIT)) begin
        integrator_alarm_limit <= wr_lim[30:0];
      end
      if (hit(wb_adr_i, `IVCA_ADR_DIVISOR)) begin
        integrator_divisor <= (wr_div[30:0] == 31'h0) ? 31'h00000001 : wr_div[30:0];
      end
      if (hit(wb_adr_i, `IVCA_ADR_INT_MASK)) begin
        int_mask <= wr_msk[2:0];
      end
    end
  end

  ivca_tick #(
    .CYCLES (SAMPLE_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (sample_tick)
  );

  assign scaled[0] = signal0_i;
  assign scaled[1] = signal1_i;
  assign scaled[2] = signal2_i;
  assign scaled[3] = signal3_i;

  // Area below zero is not counted, so negative samples add nothing
  for (genvar g = 0; g < 4; g++) begin : g_clamp
    assign clamped[g] = scaled[g][31] ? 32'h00000000 : scaled[g];
  end

  // Sample path: take, divide, add. A tick during a division is skipped;
  // the division takes far less than one sample period.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= IVCA_IDLE;
      sample    <= 32'h00000000;
      div_start <= 1'b0;
    end else begin
      div_start <= 1'b0;
      case (state)
        IVCA_IDLE: begin
          if (sample_tick) begin
            sample    <= clamped[integrator_source_select];
            div_start <= 1'b1;
            state     <= IVCA_DIVIDE;
          end
        end
        IVCA_DIVIDE: begin
          if (div_done) begin
            state <= IVCA_ADD;
          end
        end
        IVCA_ADD: begin
          state <= IVCA_IDLE;
        end
        default: begin
          state <= IVCA_IDLE;
        end
      endcase
    end
  end

  ivca_divider u_divider (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (div_start),
    .dividend_i (sample),
    .divisor_i  (integrator_divisor),
    .busy_o     (div_busy),
    .done_o     (div_done),
    .quotient_o (quotient)
  );

  assign sum_wide   = {1'b0, integrator_accumulated_value} + {1'b0, quotient};
  assign next_value = sum_wide[32] ? 32'hffffffff : sum_wide[31:0];
  assign next_over  = next_value > {1'b0, integrator_alarm_limit};

  // Loop mode restarts the area from zero at each crossing; saturate keeps counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      integrator_accumulated_value <= 32'h00000000;
    end else if (count_reset) begin
      integrator_accumulated_value <= 32'h00000000;
    end else if (state == IVCA_ADD) begin
      integrator_accumulated_value <= (next_over && loop_mode) ? 32'h00000000 : next_value;
    end
  end

  // Exceeded flag, held until count cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exceeded <= 1'b0;
    end else if (state == IVCA_ADD && next_over) begin
      exceeded <= 1'b1;
    end else if (count_reset) begin
      exceeded <= 1'b0;
    end
  end

  assign alarm_expire = loop_mode && alarm && alarm_timer == 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm       <= 1'b0;
      alarm_timer <= 32'h00000000;
    end else if (!alarm_en || count_reset) begin
      alarm       <= 1'b0;
      alarm_timer <= 32'h00000000;
    end else if (state == IVCA_ADD && next_over) begin
      alarm       <= 1'b1;
      alarm_timer <= ALARM_CYCLES[31:0] - 32'h00000001;
    end else if (alarm_expire) begin
      alarm <= 1'b0;
    end else if (alarm && loop_mode) begin
      alarm_timer <= alarm_timer - 32'h00000001;
    end
    // Saturate alarm holds: in saturate mode only a count clear or clearing the alarm enable ends it
  end

  assign int_event[`IVCA_INT_EXCEEDED_BIT]  = state == IVCA_ADD && next_over;
  assign int_event[`IVCA_INT_ALARM_END_BIT] = alarm_expire && alarm_en && !count_reset;
  assign int_event[`IVCA_INT_SAMPLE_BIT]    = state == IVCA_ADD;

  // Sticky events, write one to clear; a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status <= 3'h0;
    end else if (bus_wr && hit(wb_adr_i, `IVCA_ADR_INT_STATUS) && wb_sel_i[0]) begin
      int_status <= (int_status & ~wb_dat_i[2:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_o          <= 1'b0;
      limit_exceeded_o <= 1'b0;
      irq_o            <= 1'b0;
    end else begin
      alarm_o          <= alarm;
      limit_exceeded_o <= exceeded;
      irq_o            <= |(int_status & int_mask);
    end
  end

endmodule

/* File: hw/ivca_map.svh */
// Register offsets, field positions, reset values and timing counts of the integrating counter
`ifndef IVCA_MAP_SVH
`define IVCA_MAP_SVH

// Byte offsets of the word registers on the Wishbone bus
`define IVCA_ADR_CONFIG      8'h00
`define IVCA_ADR_SOURCE      8'h04
`define IVCA_ADR_LIMIT       8'h08
`define IVCA_ADR_DIVISOR     8'h0c
`define IVCA_ADR_VALUE       8'h10
`define IVCA_ADR_STATUS      8'h14
`define IVCA_ADR_INT_STATUS  8'h18
`define IVCA_ADR_INT_MASK    8'h1c

// Configuration fields
`define IVCA_CFG_MODE_BIT     0
`define IVCA_CFG_ALARM_EN_BIT 1

// Counter status fields
`define IVCA_STAT_ALARM_BIT    0
`define IVCA_STAT_BUSY_BIT     1
`define IVCA_STAT_EXCEEDED_BIT 4

// Interrupt status and mask fields
`define IVCA_INT_EXCEEDED_BIT  0
`define IVCA_INT_ALARM_END_BIT 1
`define IVCA_INT_SAMPLE_BIT    2

// Reset values
`define IVCA_CONFIG_RESET  2'h0
`define IVCA_SOURCE_RESET  2'h0
`define IVCA_LIMIT_RESET   31'h7fffffff
`define IVCA_DIVISOR_RESET 31'h00000001
`define IVCA_MASK_RESET    3'h0

// Timing
`define IVCA_CLK_HZ         40000000
`define IVCA_SAMPLE_MS      500
`define IVCA_ALARM_S        10
`define IVCA_SAMPLE_CYCLES  (`IVCA_CLK_HZ / 1000 * `IVCA_SAMPLE_MS)
`define IVCA_ALARM_CYCLES   (`IVCA_CLK_HZ * `IVCA_ALARM_S)

`endif

/* File: hw/ivca_pkg.sv */
// Types shared by the integrating counter modules
package ivca_pkg;

  typedef enum logic [1:0] {
    IVCA_IDLE,
    IVCA_DIVIDE,
    IVCA_ADD
  } ivca_state_t;

  typedef logic [31:0] ivca_word_t;

endpackage

/* File: hw/ivca_tick.sv */
// Prescaler producing the half-second sampling strobe
module ivca_tick
  import ivca_pkg::*;
#(
  parameter int unsigned CYCLES = 20000000
) (
  input  wire logic clk_i,   // System clock
  input  wire logic rst_i,   // Synchronous reset, active high
  output logic      tick_o   // One-cycle strobe every CYCLES clocks
);

  logic [31:0] count;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (count == CYCLES[31:0] - 32'h00000001) begin
      count  <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 32'h00000001;
      tick_o <= 1'b0;
    end
  end

endmodule

/* File: hw/ivca_divider.sv */
// Sequential restoring divider, one quotient bit per clock
module ivca_divider
  import ivca_pkg::*;
(
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_i,       // Synchronous reset, active high
  input  wire logic        start_i,     // Start pulse, ignored while busy
  input  wire logic [31:0] dividend_i,  // Dividend, taken at start
  input  wire logic [30:0] divisor_i,   // Divisor, nonzero, taken at start
  output logic             busy_o,      // Division in progress
  output logic             done_o,      // One-cycle pulse, quotient valid
  output logic [31:0]      quotient_o   // Quotient, held until next start
);

  logic [31:0] rem;
  logic [31:0] quo;
  logic [30:0] div;
  logic [5:0]  steps;
  logic [31:0] shifted;

  // Remainder stays below divisor, so its top bit is always clear
  assign shifted = {rem[30:0], quo[31]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem    <= 32'h00000000;
      quo    <= 32'h00000000;
      div    <= 31'h00000001;
      steps  <= 6'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (!busy_o) begin
      done_o <= 1'b0;
      if (start_i) begin
        rem    <= 32'h00000000;
        quo    <= dividend_i;
        div    <= divisor_i;
        steps  <= 6'h20;
        busy_o <= 1'b1;
      end
    end else begin
      if (shifted >= {1'b0, div}) begin
        rem <= shifted - {1'b0, div};
        quo <= {quo[30:0], 1'b1};
      end else begin
        rem <= shifted;
        quo <= {quo[30:0], 1'b0};
      end
      steps <= steps - 6'h01;
      if (steps == 6'h01) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

  assign quotient_o = quo;

endmodule

/* File: testbench/ivca_top_asserts.sv */
// Port-level checker for the integrating value counter
`include "ivca_map.svh"
module ivca_top_asserts
  import ivca_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = 64,
  parameter int unsigned ALARM_CYCLES  = 200
) (
  input wire logic        clk_i,            // System clock
  input wire logic        rst_i,            // Synchronous reset
  input wire logic        wb_cyc_i,         // Bus cycle
  input wire logic        wb_stb_i,         // Bus strobe
  input wire logic        wb_we_i,          // Bus write enable
  input wire logic [7:0]  wb_adr_i,         // Bus address
  input wire logic [3:0]  wb_sel_i,         // Byte selects
  input wire logic [31:0] wb_dat_i,         // Write data
  input wire logic [31:0] wb_dat_o,         // Read data
  input wire logic        wb_ack_o,         // Acknowledge
  input wire logic [31:0] signal0_i,        // Signal 0
  input wire logic [31:0] signal1_i,        // Signal 1
  input wire logic [31:0] signal2_i,        // Signal 2
  input wire logic [31:0] signal3_i,        // Signal 3
  input wire logic        alarm_o,          // Counter alarm
  input wire logic        limit_exceeded_o, // Exceeded flag
  input wire logic        irq_o             // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       tk;
  logic       wr_val;
  logic       cfg_en;
  logic [2:0] msk;
  logic [1:0] vw_age;
  assign tk     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_val = tk & wb_we_i & ({wb_adr_i[7:2], 2'b00} == `IVCA_ADR_VALUE);
  // Shadows of software settings, since the checker cannot see the registers
  always_ff @(posedge clk_i) begin
    if (rst_i) cfg_en <= 1'b0;
    else if (tk & wb_we_i & wb_sel_i[0] & ({wb_adr_i[7:2], 2'b00} == `IVCA_ADR_CONFIG))
      cfg_en <= wb_dat_i[1];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) msk <= 3'h0;
    else if (tk & wb_we_i & wb_sel_i[0] & ({wb_adr_i[7:2], 2'b00} == `IVCA_ADR_INT_MASK))
      msk <= wb_dat_i[2:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) vw_age <= 2'h3;
    else if (wr_val) vw_age <= 2'h0;
    else if (vw_age != 2'h3) vw_age <= vw_age + 2'h1;
  end
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_next; tk |=> wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i); endproperty
  property p_rdata_hold; !(tk & !wb_we_i) |=> $stable(wb_dat_o); endproperty
  property p_alarm_exc; $rose(alarm_o) |-> ##[0:1] limit_exceeded_o; endproperty
  property p_alarm_en; $rose(alarm_o) |-> (cfg_en || $past(cfg_en)); endproperty
  property p_exc_hold; $fell(limit_exceeded_o) |-> vw_age != 2'h3; endproperty
  property p_alarm_clear; wr_val |-> ##[1:3] !alarm_o; endproperty
  property p_irq_mask; irq_o |-> (msk != 3'h0) || ($past(msk) != 3'h0); endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
  a_alarm_exc: assert property (p_alarm_exc) else $error("alarm without exceeded flag");
  a_alarm_en: assert property (p_alarm_en) else $error("alarm while disabled");
  a_exc_hold: assert property (p_exc_hold) else $error("exceeded flag lost");
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm kept after reset");
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
  c_alarm: cover property ($rose(alarm_o));
  c_exc_clr: cover property ($fell(limit_exceeded_o));
  c_irq: cover property ($rose(irq_o));
endmodule

bind ivca_top ivca_top_asserts #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES),
  .ALARM_CYCLES (ALARM_CYCLES)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .signal0_i(signal0_i), .signal1_i(signal1_i),
  .signal2_i(signal2_i), .signal3_i(signal3_i), .alarm_o(alarm_o),
  .limit_exceeded_o(limit_exceeded_o), .irq_o(irq_o)
);

/* File: testbench/tb_top.sv */
// Self-checking testbench for the integrating value counter
`include "ivca_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ivca_pkg::*;
  localparam int SC = 64;
  localparam int AC = 200;
  logic        clk_i, rst_i, cyc, stb, we, ack, alarm, exc, irq;
  logic [7:0]  adr;
  logic [31:0] dat, rdat;
  logic [3:0]  sel, sel_v;
  logic [31:0] sig [4] = '{32'd1000, 32'hfffffff0, 32'd77, 32'd400};
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc_n = 0;

  ivca_top #(.SAMPLE_CYCLES(SC), .ALARM_CYCLES(AC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .signal0_i(sig[0]), .signal1_i(sig[1]), .signal2_i(sig[2]), .signal3_i(sig[3]),
    .alarm_o(alarm), .limit_exceeded_o(exc), .irq_o(irq)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("Mismatches %0d, comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hold the request until ack is sampled; the slave decides the latency
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    sel <= sel_v;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask
  task wait_irq;
    do @(posedge clk_i); while (irq !== 1'b1);
  endtask

  task automatic t_reset;
    logic [31:0] rv [9] = '{0, 0, 32'h7fffffff, 1, 0, 0, 0, 0, 0};
    for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), '1, rv[i]);
    wr(`IVCA_ADR_DIVISOR, 32'h0);
    rd_chk(`IVCA_ADR_DIVISOR, '1, 32'h1);
    wr(`IVCA_ADR_LIMIT, 32'h7fffffff);
    rd_chk(`IVCA_ADR_LIMIT, '1, 32'h7fffffff);
    // Only the low byte lane is written; the upper lanes keep their value
    sel_v = 4'h1;
    wr(`IVCA_ADR_LIMIT, 32'h12345678);
    sel_v = 4'hf;
    rd_chk(`IVCA_ADR_LIMIT, '1, 32'h7fffff78);
    wr(8'h24, 32'h5);
    rd_chk(8'h24, '1, 32'h0);
  endtask

  task t_src;
    int t0;
    logic [31:0] e;
    repeat (2 * SC) @(posedge clk_i);
    check(irq, 1'b0);
    rd_chk(`IVCA_ADR_INT_STATUS, '1, 32'h4);
    wr(`IVCA_ADR_INT_MASK, 32'h4);
    wr(`IVCA_ADR_DIVISOR, 32'h3);
    for (int s = 0; s < 4; s++) begin
      wr(`IVCA_ADR_SOURCE, 32'(s));
      wr(`IVCA_ADR_INT_STATUS, 32'h4);
      wait_irq();
      t0 = cyc_n;
      wr(`IVCA_ADR_INT_STATUS, 32'h4);
      wr(`IVCA_ADR_VALUE, 32'h0);
      wait_irq();
      check(32'(cyc_n - t0), 32'(SC));
      e = $signed(sig[s]) < 0 ? 32'h0 : sig[s] / 3;
      // Negative inputs add nothing, so source 1 reads zero
      rd_chk(`IVCA_ADR_VALUE, '1, e);
    end
  endtask

  task t_alarm;
    int n;
    logic [31:0] r;
    wr(`IVCA_ADR_DIVISOR, 32'h1);
    wr(`IVCA_ADR_LIMIT, 32'd1500);
    wr(`IVCA_ADR_CONFIG, 32'h0);
    wr(`IVCA_ADR_VALUE, 32'h0);
    do @(posedge clk_i); while (exc !== 1'b1);
    check(alarm, 1'b0);
    rd_chk(`IVCA_ADR_STATUS, 32'h11, 32'h10);
    // Crossings come every four samples, longer than the alarm, so no restart
    wr(`IVCA_ADR_CONFIG, 32'h2);
    wr(`IVCA_ADR_VALUE, 32'h0);
    @(negedge clk_i);
    check(exc, 1'b0);
    do @(posedge clk_i); while (alarm !== 1'b1);
    n = 0;
    while (alarm === 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n), 32'(AC));
    rd_chk(`IVCA_ADR_INT_STATUS, 32'h3, 32'h3);
    wr(`IVCA_ADR_CONFIG, 32'h3);
    wr(`IVCA_ADR_VALUE, 32'h0);
    do @(posedge clk_i); while (alarm !== 1'b1);
    repeat (AC + 50) @(posedge clk_i);
    check(alarm, 1'b1);
    wb(1'b0, `IVCA_ADR_VALUE, 32'h0, r);
    check(32'(r > 32'd1500), 32'h1);
    wr(`IVCA_ADR_VALUE, 32'h0);
    @(negedge clk_i);
    check(alarm, 1'b0);
    check(exc, 1'b0);
    do @(posedge clk_i); while (alarm !== 1'b1);
    wr(`IVCA_ADR_CONFIG, 32'h1);
    // Enable takes effect at the write edge, the alarm output drops two edges later
    @(posedge clk_i);
    @(negedge clk_i);
    check(alarm, 1'b0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // A hang counts as a mismatch and still ends in the closing report
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    dat = 32'h0;
    sel = 4'hf;
    sel_v = 4'hf;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_src();
    t_alarm();
    end_sim();
  end
endmodule
